//--- pkg/pmc_defines.svh
// Constants for the power mode controller: register address, bit positions,
// reset values and restart timing.
// Assumes a single 100 MHz clock and an 8-bit special function register port.
// How it works
// RL1 - Idle, power-down and reduced frequency modes exist. Only idle and power-down are built; there is no reduced frequency mode.
// RL2 - Idle stops core clock, peripherals keep running.
// RL3 - Peripherals and supervisor resets stay active in idle.
// RL4 - Watchdog is inactive during idle.
// RL5 - Interrupt or supervisor reset ends idle.
// RL6 - Port outputs hold their values in idle.
// RL7 - Writing one to bit 0 enters idle.
// RL8 - Core state is frozen while idle.
// RL9 - Interrupt clears idle bit, core resumes afterwards.
// RL10 - Supervisor reset clears idle, restarts after three cycles.
// RL11 - Power-down keeps ports, disables peripherals and supervisor.
// RL12 - Bus parks: latch low, strobes high, ones.
// RL13 - Control register at address 87h, resets 00h.
// RL14 - Bits 7 and 6 double UART rates.
// RL15 - Bit 4 set by cold reset only.
// RL16 - Bits 3 and 2 select UART B clocks.
// RL17 - Power-down stops all clocks, only reset exits.
`ifndef PMC_DEFINES_SVH
`define PMC_DEFINES_SVH
`define PMC_CONTROL_ADDR 8'h87
`define PMC_CONTROL_RESET 8'h00
`define PMC_BIT_IDLE 0
`define PMC_BIT_POWER_DOWN 1
`define PMC_BIT_TX_SELECT 2
`define PMC_BIT_RX_SELECT 3
`define PMC_BIT_POR_FLAG 4
`define PMC_BIT_RESERVED 5
`define PMC_BIT_DOUBLE_B 6
`define PMC_BIT_DOUBLE_A 7
`define PMC_WRITABLE_MASK 8'hcc
`define PMC_WARM_KEEP_MASK 8'h10
`define PMC_PORT_RESET 24'hffffff
`define PMC_BUS_PARK 8'hff
`define PMC_RESTART_MACHINE_CYCLES 3
`define PMC_CLOCKS_PER_MACHINE_CYCLE 4
`endif

//--- pkg/pmc_pkg.sv
// Types for the power mode controller: mode encoding and the state record.
// Assumes the constants header is compiled alongside.
package pmc_pkg;
    typedef enum logic [1:0]
    {
        PMC_RUN = 2'b00,
        PMC_IDLE = 2'b01,
        PMC_POWER_DOWN = 2'b11,
        PMC_RESTART = 2'b10
    } pmc_mode_type;

    typedef struct packed
    {
        pmc_mode_type mode;
        logic [7:0] control;
        logic [7:0] restartCount;
        logic [7:0] readData;
        logic coreClockEnable;
        logic periphClockEnable;
        logic watchdogEnable;
        logic supervisorEnable;
        logic coreReset;
        logic ale;
        logic programFetchStrobeN;
        logic readStrobeN;
        logic writeStrobeN;
        logic [7:0] lowAddrDataBus;
        logic lowAddrDataOe;
        logic [7:0] highAddrBus;
        logic [23:0] portOut;
    } pmc_state_type;
endpackage

//--- logic/pmc_power_mode_control.sv
// Power mode controller: control register, clock gating, restart timing,
// bus parking and port holding for the microcontroller module.
// Assumes core, peripherals and supervisor share this clock domain.
`timescale 1ns/100ps
`default_nettype none
`include "pmc_defines.svh"

module pmc_power_mode_control
    import pmc_pkg::*;
#(
    parameter int CLOCKS_PER_MACHINE_CYCLE = `PMC_CLOCKS_PER_MACHINE_CYCLE
)
(
    // Clock and reset.
    input wire logic clock,
    input wire logic resetn,
    // Special function register port.
    input wire logic [7:0] sfrAddr,
    input wire logic sfrWrite,
    input wire logic sfrRead,
    input wire logic [7:0] sfrWriteData,
    output logic [7:0] sfrReadData,
    // Wake and reset events.
    input wire logic wakeInterrupt,
    input wire logic supervisorReset,
    input wire logic watchdogReset,
    input wire logic powerOnReset,
    // Clock gates and enables.
    output logic coreClockEnable,
    output logic periphClockEnable,
    output logic watchdogEnable,
    output logic supervisorEnable,
    output logic coreReset,
    // UART controls.
    output logic uart_a_rate_double,
    output logic uart_b_rate_double,
    output logic uart_b_rx_clock_select,
    output logic uart_b_tx_clock_select,
    // External bus from the core.
    input wire logic coreAle,
    input wire logic coreFetchStrobeN,
    input wire logic coreReadStrobeN,
    input wire logic coreWriteStrobeN,
    input wire logic [7:0] coreLowAddrData,
    input wire logic coreLowAddrDataOe,
    input wire logic [7:0] coreHighAddr,
    // External bus pins.
    output logic ale,
    output logic program_fetch_strobe_n,
    output logic readStrobeN,
    output logic writeStrobeN,
    output logic [7:0] low_addr_data_bus,
    output logic lowAddrDataOe,
    output logic [7:0] high_addr_bus,
    // Port outputs.
    input wire logic [23:0] corePortOut,
    output logic [23:0] portOut
);

    // ------------------------------------------------------------
    // Constants.
    // ------------------------------------------------------------
    localparam int RestartClocks = `PMC_RESTART_MACHINE_CYCLES * CLOCKS_PER_MACHINE_CYCLE;
    localparam logic [7:0] RestartLoad = 8'(RestartClocks - 1);
    localparam pmc_state_type ResetState = '{
        mode: PMC_RUN,
        control: `PMC_CONTROL_RESET,
        restartCount: 8'h00,
        readData: 8'h00,
        coreClockEnable: 1'b1,
        periphClockEnable: 1'b1,
        watchdogEnable: 1'b1,
        supervisorEnable: 1'b1,
        coreReset: 1'b0,
        ale: 1'b0,
        programFetchStrobeN: 1'b1,
        readStrobeN: 1'b1,
        writeStrobeN: 1'b1,
        lowAddrDataBus: `PMC_BUS_PARK,
        lowAddrDataOe: 1'b0,
        highAddrBus: `PMC_BUS_PARK,
        portOut: `PMC_PORT_RESET
    };

    pmc_state_type state_reg;
    pmc_state_type state_next;
    logic hit;
    logic warmHit;
    logic sleeping;

    // ------------------------------------------------------------
    // Next state.
    // ------------------------------------------------------------
    always_comb
    begin
        state_next = state_reg;
        hit = (sfrAddr == `PMC_CONTROL_ADDR); // [RL13]
        // Watchdog cannot reset the core while the block sleeps. [RL4]
        warmHit = supervisorReset | (watchdogReset & state_reg.watchdogEnable);
        state_next.readData = (sfrRead && hit) ? state_reg.control : 8'h00;
        unique case (state_reg.mode)
            PMC_RUN:
            begin
                if (sfrWrite && hit)
                begin
                    state_next.control = (state_reg.control & ~`PMC_WRITABLE_MASK)
                        | (sfrWriteData & `PMC_WRITABLE_MASK); // [RL14] [RL16]
                    if (!sfrWriteData[`PMC_BIT_POR_FLAG])
                    begin
                        state_next.control[`PMC_BIT_POR_FLAG] = 1'b0; // [RL15]
                    end
                    if (sfrWriteData[`PMC_BIT_POWER_DOWN])
                    begin
                        state_next.control[`PMC_BIT_POWER_DOWN] = 1'b1;
                        state_next.mode = PMC_POWER_DOWN; // [RL17] [RL1]
                    end
                    else if (sfrWriteData[`PMC_BIT_IDLE])
                    begin
                        state_next.control[`PMC_BIT_IDLE] = 1'b1;
                        state_next.mode = PMC_IDLE; // [RL7] [RL1]
                    end
                end
            end
            PMC_IDLE:
            begin
                if (wakeInterrupt)
                begin
                    state_next.control[`PMC_BIT_IDLE] = 1'b0; // [RL9] [RL5]
                    state_next.mode = PMC_RUN;
                end
            end
            PMC_POWER_DOWN:
            begin
                state_next.mode = PMC_POWER_DOWN; // [RL17]
            end
            PMC_RESTART:
            begin
                if (state_reg.restartCount == 8'h00)
                begin
                    state_next.mode = PMC_RUN;
                end
                else
                begin
                    state_next.restartCount = state_reg.restartCount - 8'h01;
                end
            end
        endcase
        // Supervisor resets override everything and restart the core.
        if (powerOnReset)
        begin
            state_next.control = `PMC_CONTROL_RESET;
            state_next.control[`PMC_BIT_POR_FLAG] = 1'b1; // [RL15]
            state_next.mode = PMC_RESTART;
            state_next.restartCount = RestartLoad;
        end
        else if (warmHit)
        begin
            state_next.control = state_reg.control & `PMC_WARM_KEEP_MASK; // [RL10] [RL15]
            state_next.mode = PMC_RESTART; // [RL5] [RL10]
            state_next.restartCount = RestartLoad;
        end
        sleeping = (state_next.mode == PMC_IDLE) || (state_next.mode == PMC_POWER_DOWN);
        // Idle gates the core and the watchdog; power-down gates everything. [RL2] [RL3] [RL8] [RL11] [RL17]
        state_next.coreClockEnable = !sleeping;
        state_next.periphClockEnable = (state_next.mode != PMC_POWER_DOWN);
        state_next.supervisorEnable = (state_next.mode != PMC_POWER_DOWN);
        state_next.watchdogEnable = !sleeping; // [RL4]
        state_next.coreReset = (state_next.mode == PMC_RESTART); // [RL10]
        if (sleeping)
        begin
            // Park the external bus. [RL12]
            state_next.ale = 1'b0;
            state_next.programFetchStrobeN = 1'b1;
            state_next.readStrobeN = 1'b1;
            state_next.writeStrobeN = 1'b1;
            state_next.lowAddrDataBus = `PMC_BUS_PARK;
            state_next.lowAddrDataOe = 1'b1;
            state_next.highAddrBus = `PMC_BUS_PARK;
        end
        else
        begin
            state_next.ale = coreAle;
            state_next.programFetchStrobeN = coreFetchStrobeN;
            state_next.readStrobeN = coreReadStrobeN;
            state_next.writeStrobeN = coreWriteStrobeN;
            state_next.lowAddrDataBus = coreLowAddrData;
            state_next.lowAddrDataOe = coreLowAddrDataOe;
            state_next.highAddrBus = coreHighAddr;
            state_next.portOut = corePortOut; // [RL6] [RL11]
        end
        // The reserved bit always reads zero.
        state_next.control[`PMC_BIT_RESERVED] = 1'b0; // [RL15]
    end

    // ------------------------------------------------------------
    // State register.
    // ------------------------------------------------------------
    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn)
        begin
            state_reg <= ResetState; // [RL13]
        end
        else
        begin
            state_reg <= state_next;
        end
    end

    // ------------------------------------------------------------
    // Outputs.
    // ------------------------------------------------------------
    assign sfrReadData = state_reg.readData;
    assign coreClockEnable = state_reg.coreClockEnable;
    assign periphClockEnable = state_reg.periphClockEnable;
    assign watchdogEnable = state_reg.watchdogEnable;
    assign supervisorEnable = state_reg.supervisorEnable;
    assign coreReset = state_reg.coreReset;
    assign uart_a_rate_double = state_reg.control[`PMC_BIT_DOUBLE_A]; // [RL14]
    assign uart_b_rate_double = state_reg.control[`PMC_BIT_DOUBLE_B]; // [RL14]
    assign uart_b_rx_clock_select = state_reg.control[`PMC_BIT_RX_SELECT]; // [RL16]
    assign uart_b_tx_clock_select = state_reg.control[`PMC_BIT_TX_SELECT]; // [RL16]
    assign ale = state_reg.ale;
    assign program_fetch_strobe_n = state_reg.programFetchStrobeN;
    assign readStrobeN = state_reg.readStrobeN;
    assign writeStrobeN = state_reg.writeStrobeN;
    assign low_addr_data_bus = state_reg.lowAddrDataBus;
    assign lowAddrDataOe = state_reg.lowAddrDataOe;
    assign high_addr_bus = state_reg.highAddrBus;
    assign portOut = state_reg.portOut;

    // ------------------------------------------------------------
    // Checks.
    // ------------------------------------------------------------
    logic [7:0] restartSeen_reg;
    logic anyReset;

    assign anyReset = powerOnReset | supervisorReset | (watchdogReset & state_reg.watchdogEnable);

    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn)
        begin
            restartSeen_reg <= 8'h00;
        end
        else if (anyReset)
        begin
            restartSeen_reg <= 8'h00;
        end
        else if (state_reg.mode == PMC_RESTART)
        begin
            restartSeen_reg <= restartSeen_reg + 8'h01;
        end
        else
        begin
            restartSeen_reg <= 8'h00;
        end
    end

    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!resetn);

    idle_clock_gate_a: assert property ( // [RL2]
        state_reg.mode == PMC_IDLE |-> !coreClockEnable && periphClockEnable && supervisorEnable)
        else $error("Idle clock gating wrong.");

    idle_watchdog_off_a: assert property ( // [RL4]
        state_reg.mode == PMC_IDLE |-> !watchdogEnable)
        else $error("Watchdog active during idle.");

    idle_entry_a: assert property ( // [RL7]
        state_reg.mode == PMC_RUN && sfrWrite && hit && sfrWriteData[0] && !sfrWriteData[1]
        && !anyReset |=> state_reg.mode == PMC_IDLE && !coreClockEnable && state_reg.control[0])
        else $error("Idle not entered after write.");

    wake_exit_a: assert property ( // [RL9]
        state_reg.mode == PMC_IDLE && wakeInterrupt && !anyReset
        |=> state_reg.mode == PMC_RUN && coreClockEnable && !state_reg.control[0])
        else $error("Interrupt did not end idle.");

    restart_length_a: assert property ( // [RL10]
        state_reg.mode == PMC_RUN && $past(state_reg.mode) == PMC_RESTART
        |-> restartSeen_reg == 8'(RestartClocks))
        else $error("Restart length wrong.");

    bus_park_a: assert property ( // [RL12]
        (state_reg.mode == PMC_IDLE || state_reg.mode == PMC_POWER_DOWN)
        |-> !ale && program_fetch_strobe_n && readStrobeN && writeStrobeN
        && low_addr_data_bus == 8'hff && lowAddrDataOe && high_addr_bus == 8'hff)
        else $error("Bus not parked.");

    port_hold_a: assert property ( // [RL6]
        state_reg.mode == PMC_IDLE ##1 state_reg.mode == PMC_IDLE |-> $stable(portOut))
        else $error("Port changed during idle.");

    power_down_stay_a: assert property ( // [RL17]
        state_reg.mode == PMC_POWER_DOWN && !powerOnReset && !supervisorReset
        |=> state_reg.mode == PMC_POWER_DOWN && !periphClockEnable && !supervisorEnable)
        else $error("Power-down left without reset.");

    por_flag_a: assert property ( // [RL15]
        powerOnReset |=> state_reg.control[4] && coreReset)
        else $error("Cold reset flag not set.");

    warm_keeps_flag_a: assert property ( // [RL15]
        supervisorReset && !powerOnReset
        |=> state_reg.control[4] == $past(state_reg.control[4]) && state_reg.control[3:0] == 4'h0)
        else $error("Warm reset changed flag.");

    reserved_zero_a: assert property ( // [RL15]
        state_reg.control[5] == 1'b0)
        else $error("Reserved bit set.");

    idle_wake_c: cover property (
        state_reg.mode == PMC_RUN ##1 state_reg.mode == PMC_IDLE [*3] ##1 state_reg.mode == PMC_RUN);
    power_down_c: cover property (
        state_reg.mode == PMC_POWER_DOWN ##1 state_reg.mode == PMC_RESTART);
    idle_reset_c: cover property (
        state_reg.mode == PMC_IDLE ##1 state_reg.mode == PMC_RESTART);
    read_back_c: cover property (
        sfrRead && hit ##1 sfrReadData != 8'h00);

endmodule // pmc_power_mode_control
`default_nettype wire

//--- dv/pmc_core_model.sv
// Core side model: drives the core bus and port values.
// Assumes the shared clock and the active-low reset of the bench.
`timescale 1ns/100ps
`default_nettype none

module pmc_core_model
(
    // Clock and reset.
    input wire logic clock,
    input wire logic resetn,
    // Core bus and ports.
    output logic coreAle,
    output logic coreFetchStrobeN,
    output logic coreReadStrobeN,
    output logic coreWriteStrobeN,
    output logic [7:0] coreLowAddrData,
    output logic coreLowAddrDataOe,
    output logic [7:0] coreHighAddr,
    output logic [23:0] corePortOut
);
    logic [7:0] count_reg;

    // The pattern changes every cycle so that a held or parked value shows.
    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn)
        begin
            count_reg <= 8'h00;
        end
        else
        begin
            count_reg <= count_reg + 8'h01;
        end
    end
    assign coreAle = count_reg[0];
    assign coreFetchStrobeN = count_reg[1];
    assign coreReadStrobeN = count_reg[2];
    assign coreWriteStrobeN = count_reg[3];
    assign coreLowAddrData = count_reg;
    assign coreLowAddrDataOe = 1'b0;
    assign coreHighAddr = ~count_reg;
    assign corePortOut = {count_reg, ~count_reg, count_reg};
endmodule // pmc_core_model

`default_nettype wire

//--- dv/pmc_power_mode_control_test.sv
// Testbench for the power mode controller.
// Assumes the core model drives the core bus inputs.
`timescale 1ns/100ps
`default_nettype none
`define CHECK(w, e, g) begin compares++; if ((g) !== (e)) begin fail_count++; \
$display("unexpected %s expected %h seen %h", w, e, g); end end

module pmc_power_mode_control_test;
    import pmc_pkg::*;
    logic clock = 1'b0, resetn = 1'b0, sfrWrite = 1'b0, sfrRead = 1'b0;
    logic wakeInterrupt = 1'b0, supervisorReset = 1'b0, watchdogReset = 1'b0, powerOnReset = 1'b0;
    logic [7:0] sfrAddr = 8'h00, sfrWriteData = 8'h00, sfrReadData, lad, had, cla, chd;
    logic cce, pce, wde, sve, crs, uaD, ubD, ubR, ubT, cAle, cFs, cRs, cWs, cOe, ale, pfs, rds, wrs, ladOe;
    logic [23:0] cpo, portOut;
    int fail_count = 0, compares = 0;

    pmc_core_model u_core (.clock(clock), .resetn(resetn), .coreAle(cAle), .coreFetchStrobeN(cFs),
        .coreReadStrobeN(cRs), .coreWriteStrobeN(cWs), .coreLowAddrData(cla), .coreLowAddrDataOe(cOe),
        .coreHighAddr(chd), .corePortOut(cpo));
    pmc_power_mode_control #(.CLOCKS_PER_MACHINE_CYCLE(4)) u_dut (.clock(clock), .resetn(resetn),
        .sfrAddr(sfrAddr), .sfrWrite(sfrWrite), .sfrRead(sfrRead), .sfrWriteData(sfrWriteData),
        .sfrReadData(sfrReadData), .wakeInterrupt(wakeInterrupt), .supervisorReset(supervisorReset),
        .watchdogReset(watchdogReset), .powerOnReset(powerOnReset), .coreClockEnable(cce),
        .periphClockEnable(pce), .watchdogEnable(wde), .supervisorEnable(sve), .coreReset(crs),
        .uart_a_rate_double(uaD), .uart_b_rate_double(ubD), .uart_b_rx_clock_select(ubR),
        .uart_b_tx_clock_select(ubT), .coreAle(cAle), .coreFetchStrobeN(cFs), .coreReadStrobeN(cRs),
        .coreWriteStrobeN(cWs), .coreLowAddrData(cla), .coreLowAddrDataOe(cOe), .coreHighAddr(chd),
        .ale(ale), .program_fetch_strobe_n(pfs), .readStrobeN(rds), .writeStrobeN(wrs),
        .low_addr_data_bus(lad), .lowAddrDataOe(ladOe), .high_addr_bus(had), .corePortOut(cpo),
        .portOut(portOut));

    initial
    begin
        forever #5 clock = ~clock;
    end

    // ------------------------------------------------------------
    // Bus and event tasks.
    // ------------------------------------------------------------
    task automatic finish_test();
        $display("compares %0d mismatches %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock);
        sfrAddr <= a;
        sfrWriteData <= d;
        sfrWrite <= 1'b1;
        @(posedge clock);
        sfrWrite <= 1'b0;
        #1;
    endtask

    task automatic read_check(input logic [7:0] a, input logic [7:0] e);
        @(posedge clock);
        sfrAddr <= a;
        sfrRead <= 1'b1;
        @(posedge clock);
        sfrRead <= 1'b0;
        #1;
        `CHECK("read data", e, sfrReadData)
    endtask

    task automatic event_pulse(input int which);
        @(posedge clock);
        if (which == 0) powerOnReset <= 1'b1;
        if (which == 1) supervisorReset <= 1'b1;
        if (which == 2) watchdogReset <= 1'b1;
        if (which == 3) wakeInterrupt <= 1'b1;
        @(posedge clock);
        {powerOnReset, supervisorReset, watchdogReset, wakeInterrupt} <= 4'h0;
        #1;
    endtask

    task automatic check_restart();
        int n;
        n = 0;
        `CHECK("core reset", 1'b1, crs)
        while (crs === 1'b1 && n < 50)
        begin
            @(posedge clock);
            #1;
            n++;
        end
        `CHECK("restart cycles", 12, n)
        if (n == 50) finish_test();
    endtask

    task automatic check_parked(input logic expPce, input logic expSve);
        `CHECK("core clock", 1'b0, cce)
        `CHECK("watchdog", 1'b0, wde)
        `CHECK("periph clock", expPce, pce)
        `CHECK("supervisor", expSve, sve)
        `CHECK("bus pins", 5'h0f, {ale, pfs, rds, wrs, ladOe})
        `CHECK("bus data", 16'hffff, {lad, had})
    endtask

    // ------------------------------------------------------------
    // Scenarios.
    // ------------------------------------------------------------
    task automatic test_fields();
        logic [20:0] expBus;
        logic [23:0] expPort;
        read_check(8'h87, 8'h00);
        write_reg(8'h86, 8'hc0);
        read_check(8'h86, 8'h00);
        read_check(8'h87, 8'h00);
        write_reg(8'h87, 8'hfc);
        read_check(8'h87, 8'hcc);
        `CHECK("uart bits", 4'hf, {uaD, ubD, ubR, ubT})
        write_reg(8'h87, 8'h84);
        `CHECK("uart bits", 4'h9, {uaD, ubD, ubR, ubT})
        expBus = {cAle, cFs, cRs, cWs, cla, cOe, chd};
        expPort = cpo;
        @(posedge clock);
        #1;
        `CHECK("bus follows", expBus, {ale, pfs, rds, wrs, lad, ladOe, had})
        `CHECK("ports follow", expPort, portOut)
        $display("test fields done");
    endtask

    task automatic test_idle();
        logic [23:0] held;
        write_reg(8'h87, 8'h41);
        check_parked(1'b1, 1'b1);
        held = portOut;
        event_pulse(2);
        repeat (3) @(posedge clock);
        #1;
        `CHECK("watchdog ignored", 2'b00, {crs, cce})
        `CHECK("ports held", held, portOut)
        event_pulse(3);
        `CHECK("woken", 1'b1, cce)
        read_check(8'h87, 8'h40);
        write_reg(8'h87, 8'h01);
        event_pulse(1);
        check_restart();
        read_check(8'h87, 8'h00);
        event_pulse(2);
        check_restart();
        $display("test idle done");
    endtask

    task automatic test_power_down();
        logic [23:0] held;
        write_reg(8'h87, 8'h02);
        check_parked(1'b0, 1'b0);
        held = portOut;
        event_pulse(3);
        repeat (2) @(posedge clock);
        #1;
        `CHECK("no wake", 2'b00, {cce, pce})
        `CHECK("ports kept", held, portOut)
        event_pulse(0);
        check_restart();
        read_check(8'h87, 8'h10);
        event_pulse(1);
        check_restart();
        read_check(8'h87, 8'h10);
        write_reg(8'h87, 8'h00);
        read_check(8'h87, 8'h00);
        $display("test power down done");
    endtask

    initial
    begin
        repeat (20) @(posedge clock);
        resetn <= 1'b1;
        @(posedge clock);
        #1;
        `CHECK("run state", 3'b110, {cce, pce, crs})
        test_fields();
        test_idle();
        test_power_down();
        finish_test();
    end
endmodule // pmc_power_mode_control_test

`default_nettype wire
